/* File: src/ascp_parser.sv */
/*
 * ascp_parser: frames, decodes and executes ascii commands, and sends replies.
 * assumes a uart on mclk delivers and accepts whole characters; the mode strap is asynchronous.
 */
`timescale 1ns/1ps
module ascp_parser (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 rs232_mode,
    input  wire ascp_pkg::ascp_byte_t rx,
    output logic                      rx_ready,
    output ascp_pkg::ascp_byte_t      tx,
    input  wire logic                 tx_ready,
    output logic                      privileged_access_flag,
    output logic                      converter_freeze_state,
    output ascp_pkg::ascp_cal_t       cal,
    output logic [15:0]               dac_code,
    output logic                      dac_load
);
    import ascp_pkg::*;

    ascp_state_t r;
    ascp_state_t next_r;

    function automatic logic is_dec(input logic [7:0] c);
        return c >= 8'h30 && c <= 8'h39;
    endfunction : is_dec

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        if (is_dec(c))
            return 4'(c - 8'h30);
        else if (c >= 8'h41 && c <= 8'h46)
            return 4'(c - 8'h37);
        else if (c >= 8'h61 && c <= 8'h66)
            return 4'(c - 8'h57);
        return 4'h0;
    endfunction : hex_val

    function automatic logic [7:0] nib_char(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction : nib_char

    function automatic logic [3:0] body_len(input ascp_reply_t k);
        case (k)
            RK_PRIV, RK_FRZ: return 4'd3;
            RK_VAL:          return 4'd4;
            default:         return 4'd2;
        endcase
    endfunction : body_len

    // every character produced here is printable, apart from the closing cr
    function automatic logic [7:0] reply_char(input logic [3:0] p, input ascp_state_t s);
        logic [3:0] b;
        b = p - POS_BODY;
        if (p == 4'd0)
            return CH_START;
        if (p == 4'd1)
            return nib_char(s.addr_own[7:4]);
        if (p == 4'd2)
            return nib_char(s.addr_own[3:0]);
        if (p == 4'd3)
            return CH_COMMA;
        if (b == body_len(s.rkind))
            return CH_CR;
        case (s.rkind)
            RK_PRIV: return (b == 4'd0) ? 8'h50 : (b == 4'd1) ? 8'h3a : (s.rval[0] ? 8'h59 : 8'h4e);
            RK_FRZ:  return (b == 4'd0) ? 8'h55 : (b == 4'd1) ? 8'h3a : (s.rval[0] ? 8'h44 : 8'h4e);
            RK_VAL:  return nib_char(s.rval[4'(4'd3 - b[1:0]) * 4 +: 4]);
            RK_OK:   return (b == 4'd0) ? 8'h4f : 8'h4b;
            default: return (b == 4'd0) ? 8'h45 : 8'h52;
        endcase
    endfunction : reply_char

    logic        take;
    logic [7:0]  c;
    logic [15:0] a0;
    logic [15:0] a1;
    logic        is_mw;
    logic        is_mr;
    logic        is_wr;
    logic        to_all;
    assign take   = rx.valid && r.rx_ready && rx.data != CH_LF;
    assign c      = rx.data;
    assign a0     = r.dec[0];
    assign a1     = r.dec[1];
    assign is_mw  = r.cmd == 16'h4d57;
    assign is_mr  = r.cmd == 16'h4d52;
    assign is_wr  = r.cmd == 16'h5752;
    assign to_all = !r.mode_s2 && r.addr_rx == ADDR_ALL;

    always_comb
    begin
        next_r          = r;
        next_r.mode_s1  = rs232_mode;
        next_r.mode_s2  = r.mode_s1;
        next_r.dac_load = 1'b0;
        case (r.ph)
            P_IDLE, P_ADDR, P_CMD, P_ARG, P_SKIP:
            begin
                if (take && c == CH_START && !r.mode_s2)
                begin
                    next_r.ph  = P_ADDR;
                    next_r.cnt = 3'd0;
                end
                else if (take)
                begin
                    case (r.ph)
                        P_IDLE:
                        begin
                            if (r.mode_s2 && c != CH_CR)
                            begin
                                next_r.ph    = P_CMD;
                                next_r.cmd   = {8'h00, c};
                                next_r.cnt   = 3'd1;
                                next_r.nargs = 3'd0;
                                next_r.dec   = '0;
                                next_r.hex   = '0;
                                next_r.ch0   = '0;
                            end
                        end
                        P_ADDR:
                        begin
                            if (c == CH_CR)
                                next_r.ph = P_IDLE;
                            else if (r.cnt < 3'd2)
                            begin
                                next_r.addr_rx = {r.addr_rx[3:0], hex_val(c)};
                                next_r.cnt     = r.cnt + 3'd1;
                            end
                            else if (c == CH_COMMA && (r.addr_rx == r.addr_own || r.addr_rx == ADDR_ALL))
                            begin
                                next_r.ph    = P_CMD;
                                next_r.cmd   = '0;
                                next_r.cnt   = 3'd0;
                                next_r.nargs = 3'd0;
                                next_r.dec   = '0;
                                next_r.hex   = '0;
                                next_r.ch0   = '0;
                            end
                            else
                                next_r.ph = P_SKIP;
                        end
                        P_CMD:
                        begin
                            if (c == CH_CR)
                                next_r.ph = P_EXEC;
                            else if (c == CH_COMMA)
                            begin
                                next_r.ph  = P_ARG;
                                next_r.cnt = 3'd0;
                            end
                            else if (r.cnt < 3'd2)
                            begin
                                // longer words keep their first two letters
                                next_r.cmd = {r.cmd[7:0], c};
                                next_r.cnt = r.cnt + 3'd1;
                            end
                        end
                        P_ARG:
                        begin
                            if (c == CH_CR)
                                next_r.ph = P_EXEC;
                            else if (c == CH_COMMA)
                            begin
                                next_r.nargs = (r.nargs < 3'(NARG - 1)) ? r.nargs + 3'd1 : r.nargs;
                                next_r.cnt   = 3'd0;
                            end
                            else
                            begin
                                if (r.cnt == 3'd0)
                                    next_r.ch0[r.nargs[1:0]] = c;
                                next_r.cnt = 3'd1;
                                next_r.hex[r.nargs[1:0]] = {r.hex[r.nargs[1:0]][3:0], hex_val(c)};
                                if (is_dec(c))
                                    next_r.dec[r.nargs[1:0]] = 16'(r.dec[r.nargs[1:0]] * 16'd10 + {12'h0, hex_val(c)});
                            end
                        end
                        default:
                        begin
                            if (c == CH_CR)
                                next_r.ph = P_IDLE;
                        end
                    endcase
                end
            end
            P_EXEC:
            begin
                next_r.rkind = RK_ERR;
                next_r.rval  = '0;
                if (is_mw)
                begin
                    next_r.rkind = RK_OK;
                    if (a0 == IDX_PRIV)
                    begin
                        next_r.rkind = RK_PRIV;
                        if (a1 == 16'd1)
                            next_r.privileged_access_flag = 1'b1;
                        else if (a1 == 16'd0)
                            next_r.privileged_access_flag = 1'b0;
                        next_r.rval = {15'h0, next_r.privileged_access_flag};
                    end
                    else if (a0 == IDX_ADDR && r.hex[1] != ADDR_ALL)
                        next_r.addr_own = r.hex[1];
                    else if (!r.privileged_access_flag)
                        next_r.rkind = RK_ERR;
                    else if (a0 == IDX_VSCL)
                        next_r.cal.voltage_out_scale = a1;
                    else if (a0 == IDX_ISCL)
                        next_r.cal.current_out_scale = a1;
                    else if (a0 == IDX_IOFF)
                        next_r.cal.current_out_offset = a1;
                    else
                        next_r.rkind = RK_ERR;
                end
                else if (is_mr)
                begin
                    next_r.rkind = RK_VAL;
                    case (a0)
                        IDX_ADDR: next_r.rval = {8'h00, r.addr_own};
                        IDX_VSCL: next_r.rval = r.cal.voltage_out_scale;
                        IDX_ISCL: next_r.rval = r.cal.current_out_scale;
                        IDX_IOFF: next_r.rval = r.cal.current_out_offset;
                        IDX_PRIV: next_r.rval = {15'h0, r.privileged_access_flag};
                        default:  next_r.rkind = RK_ERR;
                    endcase
                end
                else if (is_wr && a0 == CHAN_FRZ && (r.ch0[1] == 8'h44 || r.ch0[1] == 8'h4e))
                begin
                    next_r.rkind = RK_FRZ;
                    next_r.converter_freeze_state = r.ch0[1] == 8'h44;
                    next_r.rval = {15'h0, next_r.converter_freeze_state};
                end
                else if (is_wr && a0 == CHAN_DAC)
                begin
                    next_r.rkind    = RK_OK;
                    next_r.dac_code = a1;
                    next_r.dac_load = 1'b1;
                end
                next_r.ph  = to_all ? P_IDLE : P_TX;
                next_r.pos = r.mode_s2 ? POS_BODY : 4'd0;
            end
            P_TX:
            begin
                if (!r.tx.valid || tx_ready)
                begin
                    if (r.pos > POS_BODY + body_len(r.rkind))
                    begin
                        next_r.tx.valid = 1'b0;
                        next_r.ph       = P_IDLE;
                    end
                    else
                    begin
                        next_r.tx.valid = 1'b1;
                        next_r.tx.data  = reply_char(r.pos, r);
                        next_r.pos      = r.pos + 4'd1;
                    end
                end
            end
            default:
                next_r.ph = P_IDLE;
        endcase
        next_r.rx_ready = next_r.ph != P_EXEC && next_r.ph != P_TX;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            r          <= '0;
            r.ph       <= P_IDLE;
            r.addr_own <= ADDR_RST;
            r.rkind    <= RK_OK;
            r.cal      <= {SCALE_RST, SCALE_RST, SCALE_RST};
        end
        else
            r <= next_r;
    end

    assign rx_ready               = r.rx_ready;
    assign tx                     = r.tx;
    assign privileged_access_flag = r.privileged_access_flag;
    assign converter_freeze_state = r.converter_freeze_state;
    assign cal                    = r.cal;
    assign dac_code               = r.dac_code;
    assign dac_load               = r.dac_load;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence exec_store(logic [15:0] idx);
        r.ph == P_EXEC && is_mw && a0 == idx;
    endsequence

    priv_grant_a: assert property (exec_store(IDX_PRIV) ##0 (a1 == 16'd1) |=> r.privileged_access_flag)
        else $error("privilege not granted");
    priv_revoke_a: assert property (exec_store(IDX_PRIV) ##0 (a1 == 16'd0)
        |=> !r.privileged_access_flag && r.rkind == RK_PRIV && r.rval == 16'd0)
        else $error("privilege not revoked");
    freeze_set_a: assert property (r.ph == P_EXEC && is_wr && a0 == CHAN_FRZ && r.ch0[1] == 8'h44
        |=> converter_freeze_state)
        else $error("converter not frozen");
    freeze_clear_a: assert property (r.ph == P_EXEC && is_wr && a0 == CHAN_FRZ && r.ch0[1] == 8'h4e
        |=> !converter_freeze_state)
        else $error("converter not released");
    dac_load_a: assert property (r.ph == P_EXEC && is_wr && a0 == CHAN_DAC
        |=> dac_load && dac_code == $past(a1))
        else $error("raw code not loaded");
    cal_guard_a: assert property (!r.privileged_access_flag && r.ph == P_EXEC |=> $stable(cal))
        else $error("calibration changed without privilege");
    lf_drop_a: assert property (rx.valid && rx.data == CH_LF && r.ph == P_ARG
        |=> $stable(r.dec) && $stable(r.nargs))
        else $error("line feed entered frame");
    global_quiet_a: assert property (r.ph == P_EXEC && to_all |=> r.ph == P_IDLE ##1 !tx.valid)
        else $error("reply sent to global frame");
    // a start or cr in the comma slot restarts or ends the frame instead
    foreign_skip_a: assert property (take && c != CH_START && c != CH_CR && r.ph == P_ADDR
        && r.cnt == 3'd2 && r.addr_rx != r.addr_own && r.addr_rx != ADDR_ALL |=> r.ph == P_SKIP)
        else $error("foreign frame not skipped");
    reply_frame_a: assert property (r.ph == P_EXEC && !to_all && !r.mode_s2 ##1 tx_ready [*2]
        |-> tx.valid && tx.data == CH_START)
        else $error("reply without start character");
    addr_reset_a: assert property ($rose(rst_n) |-> r.addr_own == ADDR_RST)
        else $error("wrong address after reset");
endmodule : ascp_parser

/* File: pkg/ascp_pkg.sv */
/*
 * ascp_pkg: constants, types and state record of the ascii command parser.
 * assumes a byte-wide receive and transmit stream on the same clock as the parser.
 */
package ascp_pkg;
    localparam logic [7:0]  CH_START  = 8'h21;
    localparam logic [7:0]  CH_COMMA  = 8'h2c;
    localparam logic [7:0]  CH_CR     = 8'h0d;
    localparam logic [7:0]  CH_LF     = 8'h0a;
    localparam logic [7:0]  ADDR_RST  = 8'h11;
    localparam logic [7:0]  ADDR_ALL  = 8'h00;
    localparam logic [15:0] IDX_ADDR  = 16'd7;
    localparam logic [15:0] IDX_VSCL  = 16'd25;
    localparam logic [15:0] IDX_ISCL  = 16'd27;
    localparam logic [15:0] IDX_IOFF  = 16'd28;
    localparam logic [15:0] IDX_PRIV  = 16'd1000;
    localparam logic [15:0] CHAN_DAC  = 16'd1;
    localparam logic [15:0] CHAN_FRZ  = 16'd4;
    localparam logic [15:0] SCALE_RST = 16'h0000;
    localparam logic [3:0]  POS_BODY  = 4'd4;
    localparam int          NARG      = 4;

    typedef enum logic [2:0] {P_IDLE, P_ADDR, P_CMD, P_ARG, P_SKIP, P_EXEC, P_TX} ascp_phase_t;
    typedef enum logic [2:0] {RK_PRIV, RK_FRZ, RK_VAL, RK_OK, RK_ERR} ascp_reply_t;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } ascp_byte_t;

    typedef struct packed {
        logic [15:0] voltage_out_scale;
        logic [15:0] current_out_scale;
        logic [15:0] current_out_offset;
    } ascp_cal_t;

    typedef struct packed {
        ascp_phase_t        ph;
        logic               mode_s1;
        logic               mode_s2;
        logic [7:0]         addr_own;
        logic [7:0]         addr_rx;
        logic [2:0]         cnt;
        logic [15:0]        cmd;
        logic [2:0]         nargs;
        logic [3:0][15:0]   dec;
        logic [3:0][7:0]    hex;
        logic [3:0][7:0]    ch0;
        logic               privileged_access_flag;
        logic               converter_freeze_state;
        ascp_cal_t          cal;
        logic [15:0]        dac_code;
        logic               dac_load;
        logic               rx_ready;
        ascp_byte_t         tx;
        ascp_reply_t        rkind;
        logic [15:0]        rval;
        logic [3:0]         pos;
    } ascp_state_t;
endpackage : ascp_pkg

/* File: tb/ascp_host_model.sv */
/*
 * ascp_host_model: terminal on the far side of the parser's character streams.
 * assumes the bench calls send from a rising mclk edge and reads got afterwards.
 */
`timescale 1ns/1ps
module ascp_host_model (
    input  wire logic                 mclk,
    input  wire logic                 rx_ready,
    input  wire ascp_pkg::ascp_byte_t tx,
    output ascp_pkg::ascp_byte_t      rx,
    output logic                      tx_ready
);
    import ascp_pkg::*;
    logic       slow;
    logic [7:0] got[$];

    initial
    begin
        rx = '{data: 8'h00, valid: 1'b0};
        tx_ready = 1'b1;
        slow = 1'b0;
    end

    // slow mode refuses every other cycle to stretch the reply
    always @(posedge mclk)
        tx_ready <= slow ? ~tx_ready : 1'b1;

    // negedge view equals what the next rising edge samples, so no race
    always @(negedge mclk)
        if (tx.valid === 1'b1 && tx_ready === 1'b1)
            got.push_back(tx.data);

    task put(input logic [7:0] c);
        rx <= '{data: c, valid: 1'b1};
        @(negedge mclk);
        while (rx_ready !== 1'b1)
            @(negedge mclk);
        @(posedge mclk);
    endtask : put

    task send(input string s);
        for (int i = 0; i < s.len(); i++)
            put(s[i]);
        put(CH_CR);
        // released line shows the inverse, not a stale carriage return
        rx <= '{data: ~CH_CR, valid: 1'b0};
    endtask : send
endmodule : ascp_host_model

/* File: tb/ascii_serial_command_parser_tb.sv */
/*
 * ascii_serial_command_parser_tb: directed tests of the parser through a host model.
 * assumes ascp_parser, ascp_host_model and ascp_pkg are compiled before it.
 */
`timescale 1ns/1ps
module ascii_serial_command_parser_tb;
    import ascp_pkg::*;
    logic        mclk;
    logic        rst_n;
    logic        rs232_mode;
    ascp_byte_t  rx;
    logic        rx_ready;
    ascp_byte_t  tx;
    logic        tx_ready;
    logic        privileged_access_flag;
    logic        converter_freeze_state;
    ascp_cal_t   cal;
    logic [15:0] dac_code;
    logic        dac_load;
    int          fails = 0;
    int          samples_checked = 0;
    int          loads = 0;

    ascp_parser ascp_parser_inst (.mclk(mclk), .rst_n(rst_n), .rs232_mode(rs232_mode), .rx(rx),
        .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .privileged_access_flag(privileged_access_flag),
        .converter_freeze_state(converter_freeze_state), .cal(cal), .dac_code(dac_code), .dac_load(dac_load));

    ascp_host_model ascp_host_model_inst (.mclk(mclk), .rx_ready(rx_ready), .tx(tx), .rx(rx),
        .tx_ready(tx_ready));

    always @(posedge mclk)
        if (dac_load === 1'b1)
            loads++;

    task chk(input bit ok, input string msg);
        samples_checked++;
        if (!ok)
        begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    // empty expectation means the frame must draw no reply at all
    task run(input string f, input string e);
        int         n;
        bit         ok;
        logic [7:0] q[$];
        @(posedge mclk);
        ascp_host_model_inst.got.delete();
        ascp_host_model_inst.send(f);
        n = 0;
        if (e.len() == 0)
        begin
            repeat (40) @(negedge mclk);
            chk(ascp_host_model_inst.got.size() == 0, {"unexpected reply to ", f});
        end
        else
        begin
            while (n < 300 && ascp_host_model_inst.got.size() <= e.len())
            begin
                @(negedge mclk);
                n++;
            end
            q = ascp_host_model_inst.got;
            ok = (q.size() == e.len() + 1) && (q[e.len()] === CH_CR);
            for (int i = 0; i < e.len(); i++)
                ok &= (q[i] === e[i]);
            chk(ok, {"bad reply to ", f});
        end
    endtask : run

    task t_reset();
        @(negedge mclk);
        chk(cal === '0 && dac_code === 16'h0000 && dac_load === 1'b0, "reset outputs");
        chk(privileged_access_flag === 1'b0 && converter_freeze_state === 1'b0, "reset flags");
        run("!11,MR,7", "!11,0011");
        $display("test reset done");
    endtask : t_reset

    task t_cal();
        run("!11,MW,25,4660", "!11,ER");
        chk(cal.voltage_out_scale === 16'h0000, "store without privilege");
        run("!11,MW,1000,1", "!11,P:Y");
        chk(privileged_access_flag === 1'b1, "privilege not granted");
        run("!11,MR,1000", "!11,0001");
        ascp_host_model_inst.slow = 1'b1;
        run("!11,MW,25,4660", "!11,OK");
        run("!11,MW,27\n,4096", "!11,OK");
        run("!11,MW,28,9029", "!11,OK");
        chk(cal.voltage_out_scale === 16'h1234, "voltage scale");
        chk(cal.current_out_scale === 16'h1000, "current scale");
        chk(cal.current_out_offset === 16'h2345, "current offset");
        run("!11,MR,25", "!11,1234");
        run("!11,MR,28", "!11,2345");
        run("!11,MR,27", "!11,1000");
        ascp_host_model_inst.slow = 1'b0;
        run("!11,MW,1000,0", "!11,P:N");
        chk(privileged_access_flag === 1'b0, "privilege not revoked");
        run("!11,MW,27,1", "!11,ER");
        chk(cal.current_out_scale === 16'h1000, "store after revoke");
        $display("test cal done");
    endtask : t_cal

    task t_conv();
        int l0;
        run("!11,WRITE,4,D,0,0", "!11,U:D");
        chk(converter_freeze_state === 1'b1, "freeze");
        l0 = loads;
        run("!11,WRITE,1,4000", "!11,OK");
        chk(dac_code === 16'd4000 && loads == l0 + 1, "raw code 4000");
        run("!11,WRITE,1,0", "!11,OK");
        chk(dac_code === 16'h0000 && loads == l0 + 2, "raw code zero");
        run("!11,WRITE,4,N", "!11,U:N");
        chk(converter_freeze_state === 1'b0, "resume");
        run("!11,XY,1", "!11,ER");
        run("!11,MR,99", "!11,ER");
        $display("test conv done");
    endtask : t_conv

    task t_addr();
        run("!22,WRITE,4,D", "");
        chk(converter_freeze_state === 1'b0, "foreign frame executed");
        run("!00,WRITE,4,D", "");
        chk(converter_freeze_state === 1'b1, "global frame not executed");
        run("!4!11,MR,7", "!11,0011");
        run("!11,MW,7,42", "!42,OK");
        run("!11,MR,7", "");
        run("!42,WRITE,4,N", "!42,U:N");
        chk(converter_freeze_state === 1'b0, "new address ignored");
        $display("test addr done");
    endtask : t_addr

    task t_rs232();
        @(posedge mclk);
        rs232_mode <= 1'b1;
        repeat (3) @(posedge mclk);
        run("MR,7", "0042");
        $display("test rs232 done");
    endtask : t_rs232

    // reset in mid-run must bring back the factory address and clear calibration
    task t_rerst();
        @(posedge mclk);
        rst_n      <= 1'b0;
        rs232_mode <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        run("!11,MR,7", "!11,0011");
        chk(cal === '0 && privileged_access_flag === 1'b0, "state after second reset");
        $display("test rerst done");
    endtask : t_rerst

    task end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // whole run needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        rst_n = 1'b0;
        rs232_mode = 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_cal();
        t_conv();
        t_addr();
        t_rs232();
        t_rerst();
        end_of_test();
    end
endmodule : ascii_serial_command_parser_tb
